// file: include/pepw_pkg.sv
// constants for the host-side controller of a parallel page-write eeprom
// assumes a 125 MHz system clock and pins sampled as synchronous inputs
package pepw_pkg;

  // ==========================================================
  // clock and device timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_FILTER_NS = 15;   // device glitch filter on strobes
  localparam int T_ACC_NS = 150;     // read access time
  localparam int T_BLW_US = 150;     // byte load window
  localparam int T_LOCKOUT_MS = 5;   // power-up write lockout
  // strobe low time: rounded up, plus one cycle since the filter figure is typical
  localparam int STROBE_CYC = (T_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLW_CYC = (T_BLW_US * 1000) / CLK_PERIOD_NS;
  localparam int LOCKOUT_CYC = (T_LOCKOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_GUARD_CYC = 8;  // margin for issue latency into the window
  localparam int CNT_W = 20;
  localparam int STB_CNT_W = 5;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_W = 7;
  localparam logic [6:0] ID_PAGE = 7'h7f;  // id area at 1fc0..1fff
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [1:0] SEQ_LEN = 2'h3;

  // ==========================================================
  // command codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_WRITE_PROT = 3'h2;
  localparam logic [2:0] OP_LOCK_ON = 3'h3;
  localparam logic [2:0] OP_LOCK_OFF = 3'h4;

  // command prefix kinds
  localparam logic [1:0] SEQ_NONE = 2'h0;
  localparam logic [1:0] SEQ_ON = 2'h1;
  localparam logic [1:0] SEQ_OFF = 2'h2;

endpackage

// file: hdl/pepw_strobe.sv
// single pin cycle engine: one read or one write strobe on the eeprom bus
// assumes the caller waits for done before the next start
`timescale 1ns/1ps
module pepw_strobe (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request
  input wire logic start,
  input wire logic write,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  // answer
  output logic done,
  output logic [7:0] rdata,
  // pins
  output logic [12:0] addr_o,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe
);

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD = 4'h8
  } pepw_stb_st_t;

  typedef struct packed {
    pepw_stb_st_t st;
    logic [pepw_pkg::STB_CNT_W-1:0] cnt;
    logic wr;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic done;
    logic [7:0] rdata;
  } pepw_stb_t;

  localparam logic [4:0] WR_LAST = 5'(pepw_pkg::STROBE_CYC - 1);
  localparam logic [4:0] RD_LAST = 5'(pepw_pkg::ACC_CYC - 1);

  pepw_stb_t s_q;
  pepw_stb_t s_d;

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (start) begin
          s_d.st = ST_SETUP;
          s_d.wr = write;
          s_d.addr = addr;
          s_d.wdata = wdata;
          s_d.cnt = '0;
          s_d.ce_n = 1'b0;
          s_d.oe_n = write;  // gate stays high through any write
          s_d.dq_oe = write; // released on reads so the device can drive
        end
      end
      ST_SETUP: begin
        s_d.st = ST_STROBE;
        // address is taken at this later falling edge of the write strobe
        if (s_q.wr) begin
          s_d.we_n = 1'b0;
        end
      end
      ST_STROBE: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.wr && s_q.cnt == WR_LAST) begin
          // long enough to pass the glitch filter
          s_d.we_n = 1'b1; // data taken at this first rising edge
          s_d.st = ST_HOLD;
        end else if (!s_q.wr && s_q.cnt == RD_LAST) begin
          s_d.rdata = dq_i;
          s_d.oe_n = 1'b1;
          s_d.ce_n = 1'b1;
          s_d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // chip select rises after the write strobe, data held one cycle more
        s_d.ce_n = 1'b1;
        s_d.dq_oe = 1'b0;
        s_d.done = 1'b1;
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.ce_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.we_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign rdata = s_q.rdata;
  assign addr_o = s_q.addr;
  assign ce_n = s_q.ce_n;
  assign oe_n = s_q.oe_n;
  assign we_n = s_q.we_n;
  assign dq_o = s_q.wdata;
  assign dq_oe = s_q.dq_oe;

endmodule

// file: hdl/pepw_host.sv
// host controller for a parallel page-write eeprom: reads, page loads,
// completion polling and the write-lock command sequences
// assumes a single device on the pins and one outstanding command at a time
`timescale 1ns/1ps
module pepw_host #(
  parameter int BLW_CYC = pepw_pkg::BLW_CYC,
  parameter int LOCKOUT_CYC = pepw_pkg::LOCKOUT_CYC,
  // command sequences, entry 0 issued first
  parameter logic [2:0][12:0] SEQ_ON_ADDR = {13'h0003, 13'h0002, 13'h0001},
  parameter logic [2:0][7:0] SEQ_ON_DATA = {8'h33, 8'h22, 8'h11},
  parameter logic [2:0][12:0] SEQ_OFF_ADDR = {13'h0006, 13'h0005, 13'h0004},
  parameter logic [2:0][7:0] SEQ_OFF_DATA = {8'h66, 8'h55, 8'h44}
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // command
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [2:0] CMD_OP,
  input wire logic [12:0] CMD_ADDR,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_LAST,
  input wire logic CMD_ID,
  // answer
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  // supply
  input wire logic SUPPLY_GOOD,
  output logic WRITE_READY,
  // eeprom pins
  output logic [12:0] EE_ADDR,
  output logic EE_CE_N,
  output logic EE_OE_N,
  output logic EE_WE_N,
  input wire logic [7:0] EE_DQ_I,
  output logic [7:0] EE_DQ_O,
  output logic EE_DQ_OE,
  output logic EE_ID_HV
);

  // ==========================================================
  // state
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ISSUE = 6'h02,
    S_WAIT = 6'h04,
    S_GAP = 6'h08,
    S_PREAD = 6'h10,
    S_PWAIT = 6'h20
  } pepw_st_t;

  typedef struct packed {
    pepw_st_t st;
    logic wr_ok;
    logic [pepw_pkg::CNT_W-1:0] lock_cnt;
    logic [pepw_pkg::CNT_W-1:0] gap_cnt;
    logic [6:0] page;
    logic last_id;
    logic [12:0] last_addr;
    logic [7:0] last_data;
    logic [1:0] seq_idx;
    logic [1:0] seq_kind;
    logic [2:0] op;
    logic [12:0] addr;
    logic [7:0] data;
    logic last;
    logic id;
    logic after_poll;
    logic end_rsp;
    logic tog_only;
    logic poll_n;
    logic [7:0] first_rd;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic go;
    logic go_wr;
    logic [12:0] go_addr;
    logic [7:0] go_data;
    logic id_hv;
  } pepw_host_t;

  localparam logic [19:0] LOCK_LIM = 20'(LOCKOUT_CYC);
  localparam logic [19:0] GAP_LIM = 20'(BLW_CYC - pepw_pkg::GAP_GUARD_CYC);

  pepw_host_t s_q;
  pepw_host_t s_d;
  logic stb_done;
  logic [7:0] stb_rdata;
  logic [12:0] eff_addr;
  logic in_seq;

  // prefix kind for a command
  function automatic logic [1:0] seq_of(input logic [2:0] op);
    logic [1:0] k;
    k = pepw_pkg::SEQ_NONE;
    if (op == pepw_pkg::OP_LOCK_OFF) begin
      k = pepw_pkg::SEQ_OFF;
    end else if (op == pepw_pkg::OP_LOCK_ON || op == pepw_pkg::OP_WRITE_PROT) begin
      k = pepw_pkg::SEQ_ON;
    end
    return k;
  endfunction

  // id accesses are forced into the top page
  assign eff_addr = s_q.id ? {pepw_pkg::ID_PAGE, s_q.addr[5:0]} : s_q.addr;
  assign in_seq = (s_q.seq_kind != pepw_pkg::SEQ_NONE) && (s_q.seq_idx != pepw_pkg::SEQ_LEN);

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;
    s_d.rsp_valid = 1'b0;

    // writes held off until supply is good and the lockout has run
    if (!SUPPLY_GOOD) begin
      s_d.lock_cnt = '0;
      s_d.wr_ok = 1'b0;
    end else if (s_q.lock_cnt == LOCK_LIM) begin
      s_d.wr_ok = 1'b1;
    end else begin
      s_d.lock_cnt = s_q.lock_cnt + 1'b1;
    end

    unique case (s_q.st)
      S_IDLE: begin
        if (s_q.cmd_ready && CMD_VALID) begin
          s_d.op = CMD_OP;
          s_d.addr = CMD_ADDR;
          s_d.data = CMD_DATA;
          s_d.last = CMD_LAST;
          s_d.id = CMD_ID;
          s_d.seq_kind = seq_of(CMD_OP);
          s_d.seq_idx = '0;
          s_d.cmd_ready = 1'b0;
          s_d.st = S_ISSUE;
        end
      end
      S_ISSUE: begin
        // any write, prefix included, waits out the lockout
        if (s_q.op == pepw_pkg::OP_READ || s_q.wr_ok) begin
          s_d.go = 1'b1;
          s_d.st = S_WAIT;
          s_d.go_wr = 1'b1;
          s_d.id_hv = 1'b0;
          if (in_seq) begin
            // prefix bytes go back to back, well inside the window
            if (s_q.seq_kind == pepw_pkg::SEQ_OFF) begin
              s_d.go_addr = SEQ_OFF_ADDR[s_q.seq_idx];
              s_d.go_data = SEQ_OFF_DATA[s_q.seq_idx];
            end else begin
              s_d.go_addr = SEQ_ON_ADDR[s_q.seq_idx];
              s_d.go_data = SEQ_ON_DATA[s_q.seq_idx];
            end
          end else begin
            s_d.go_wr = (s_q.op != pepw_pkg::OP_READ);
            s_d.go_addr = eff_addr;
            s_d.go_data = s_q.data;
            s_d.id_hv = s_q.id;
          end
        end
      end
      S_WAIT: begin
        if (stb_done) begin
          if (in_seq) begin
            s_d.seq_idx = s_q.seq_idx + 1'b1;
            s_d.st = S_ISSUE;
            if (s_q.seq_idx == 2'h2 && s_q.op != pepw_pkg::OP_WRITE_PROT) begin
              // lock change: wait out the program time by toggle polling
              s_d.last_addr = s_q.go_addr;
              s_d.last_id = 1'b0;
              s_d.tog_only = 1'b1; // sequence data is not stored
              s_d.end_rsp = 1'b1;
              s_d.after_poll = 1'b0;
              s_d.poll_n = 1'b0;
              s_d.st = S_PREAD;
            end
          end else if (s_q.op == pepw_pkg::OP_READ) begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = stb_rdata;
            s_d.cmd_ready = 1'b1;
            s_d.st = S_IDLE;
          end else begin
            // byte loaded into the page; low bits pick the slot
            s_d.last_addr = eff_addr;
            s_d.last_data = s_q.data;
            s_d.last_id = s_q.id;
            s_d.page = eff_addr[12:6];
            s_d.gap_cnt = '0;
            s_d.tog_only = 1'b0;
            s_d.poll_n = 1'b0;
            s_d.after_poll = 1'b0;
            s_d.end_rsp = 1'b1;
            if (s_q.last) begin
              s_d.st = S_PREAD;
            end else begin
              // a last byte answers only once polling ends, so one answer per command
              s_d.rsp_valid = 1'b1;
              s_d.cmd_ready = 1'b1;
              s_d.st = S_GAP;
            end
          end
        end
      end
      S_GAP: begin
        s_d.gap_cnt = s_q.gap_cnt + 1'b1;
        if (s_q.cmd_ready && CMD_VALID) begin
          s_d.op = CMD_OP;
          s_d.addr = CMD_ADDR;
          s_d.data = CMD_DATA;
          s_d.last = CMD_LAST;
          s_d.id = CMD_ID;
          s_d.seq_idx = '0;
          s_d.cmd_ready = 1'b0;
          if ((CMD_OP == pepw_pkg::OP_WRITE || CMD_OP == pepw_pkg::OP_WRITE_PROT) &&
              CMD_ID == s_q.last_id &&
              (CMD_ID ? pepw_pkg::ID_PAGE : CMD_ADDR[12:6]) == s_q.page) begin
            // same page: keep loading, prefix already given at page start
            s_d.seq_kind = pepw_pkg::SEQ_NONE;
            s_d.st = S_ISSUE;
          end else begin
            // other page or a read: finish this load first
            s_d.seq_kind = seq_of(CMD_OP);
            s_d.after_poll = 1'b1;
            s_d.end_rsp = 1'b0;
            s_d.st = S_PREAD;
          end
        end else if (s_q.gap_cnt == GAP_LIM) begin
          // window closing: the device programs what it holds
          s_d.cmd_ready = 1'b0;
          s_d.end_rsp = 1'b0;
          s_d.st = S_PREAD;
        end
      end
      S_PREAD: begin
        // poll the last byte written
        s_d.go = 1'b1;
        s_d.go_wr = 1'b0;
        s_d.go_addr = s_q.last_addr;
        s_d.id_hv = s_q.last_id;
        s_d.st = S_PWAIT;
      end
      S_PWAIT: begin
        if (stb_done) begin
          s_d.first_rd = stb_rdata;
          s_d.poll_n = 1'b1;
          s_d.st = S_PREAD;
          // done when bit 6 stops toggling and, unless tog_only is set, bit 7 reads true
          if (s_q.poll_n &&
              s_q.first_rd[pepw_pkg::TOGGLE_BIT] == stb_rdata[pepw_pkg::TOGGLE_BIT] &&
              (s_q.tog_only ||
               stb_rdata[pepw_pkg::POLL_BIT] == s_q.last_data[pepw_pkg::POLL_BIT])) begin
            s_d.poll_n = 1'b0;
            if (s_q.after_poll) begin
              s_d.after_poll = 1'b0;
              s_d.st = S_ISSUE;
            end else begin
              s_d.rsp_valid = s_q.end_rsp;
              s_d.rsp_data = stb_rdata;
              s_d.cmd_ready = 1'b1;
              s_d.st = S_IDLE;
            end
          end
        end
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.cmd_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // pin cycle engine
  pepw_strobe u_strobe (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(s_q.go),
    .write(s_q.go_wr),
    .addr(s_q.go_addr),
    .wdata(s_q.go_data),
    .done(stb_done),
    .rdata(stb_rdata),
    .addr_o(EE_ADDR),
    .ce_n(EE_CE_N),
    .oe_n(EE_OE_N),
    .we_n(EE_WE_N),
    .dq_i(EE_DQ_I),
    .dq_o(EE_DQ_O),
    .dq_oe(EE_DQ_OE)
  );

  assign CMD_READY = s_q.cmd_ready;
  assign RSP_VALID = s_q.rsp_valid;
  assign RSP_DATA = s_q.rsp_data;
  assign WRITE_READY = s_q.wr_ok;
  assign EE_ID_HV = s_q.id_hv;

endmodule

// file: verif/pepw_host_props.sv
// pin and supply checker for the eeprom host controller
// assumes it is bound onto pepw_host and sees only its ports
`timescale 1ns/1ps
module pepw_host_props #(
  parameter int LOCKOUT_CYC = 50
) (
  // clock, reset and supply
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SUPPLY_GOOD,
  input wire logic WRITE_READY,
  // eeprom pins
  input wire logic [12:0] EE_ADDR,
  input wire logic EE_CE_N,
  input wire logic EE_OE_N,
  input wire logic EE_WE_N,
  input wire logic [7:0] EE_DQ_O,
  input wire logic EE_DQ_OE,
  input wire logic EE_ID_HV
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  // ==========================================================
  // supply counter; a drop clears it, so a glitch restarts the lockout
  int sup_cnt;
  always_ff @(posedge CLK) begin
    if (!RESET_N || !SUPPLY_GOOD) begin
      sup_cnt <= 0;
    end else if (sup_cnt < 1000000) begin
      sup_cnt <= sup_cnt + 1;
    end
  end

  // ==========================================================
  // strobe shape
  sequence strobe_low;
    !EE_WE_N [*3] ##1 EE_WE_N;
  endsequence

  AST_WR_SELECT: assert property (!EE_WE_N |-> !EE_CE_N && EE_OE_N)
    else $error("write strobe without select or with gate low");
  AST_READ_GATE: assert property (!EE_OE_N |-> EE_WE_N && !EE_CE_N && !EE_DQ_OE)
    else $error("read gate with strobe low or host driving");
  AST_STROBE_WIDTH: assert property ($fell(EE_WE_N) |-> strobe_low)
    else $error("write strobe not three cycles low");
  AST_DATA_HELD: assert property (!EE_WE_N |-> $stable(EE_DQ_O) && $stable(EE_ADDR) && EE_DQ_OE)
    else $error("address or data moved under the strobe");
  AST_WE_BEFORE_CE: assert property ($rose(EE_WE_N) |-> !EE_CE_N && EE_DQ_OE)
    else $error("select or data released before strobe rise");
  AST_NO_EARLY_READY: assert property (sup_cnt > 0 && sup_cnt < LOCKOUT_CYC |-> !WRITE_READY)
    else $error("write ready before lockout elapsed");
  AST_LATE_READY: assert property (sup_cnt > LOCKOUT_CYC + 2 |-> WRITE_READY)
    else $error("write ready missing after lockout");
  AST_SUPPLY_DROP: assert property (!SUPPLY_GOOD [*2] |=> !WRITE_READY)
    else $error("write ready kept without supply");
  AST_GATED_WRITE: assert property ($fell(EE_WE_N) |-> WRITE_READY)
    else $error("write strobe while writes blocked");
  AST_ID_PAGE: assert property (EE_ID_HV && !EE_CE_N |-> EE_ADDR[12:6] == 7'h7f)
    else $error("id access outside the id page");
endmodule

bind pepw_host pepw_host_props #(.LOCKOUT_CYC(LOCKOUT_CYC)) i_props (
  .CLK(CLK), .RESET_N(RESET_N), .SUPPLY_GOOD(SUPPLY_GOOD), .WRITE_READY(WRITE_READY),
  .EE_ADDR(EE_ADDR), .EE_CE_N(EE_CE_N), .EE_OE_N(EE_OE_N), .EE_WE_N(EE_WE_N),
  .EE_DQ_O(EE_DQ_O), .EE_DQ_OE(EE_DQ_OE), .EE_ID_HV(EE_ID_HV));

// file: verif/pepw_eeprom_model.sv
// behavioural page-write eeprom on the far side of the host pins
// assumes pins sampled on the host clock; supply sensing left to the host
`timescale 1ns/1ps
module pepw_eeprom_model #(
  parameter int WIN_CYC = 240,
  parameter int PROG_CYC = 300,
  parameter logic [2:0][12:0] ON_A = {13'h0003, 13'h0002, 13'h0001},
  parameter logic [2:0][7:0] ON_D = {8'h33, 8'h22, 8'h11},
  parameter logic [2:0][12:0] OFF_A = {13'h0006, 13'h0005, 13'h0004},
  parameter logic [2:0][7:0] OFF_D = {8'h66, 8'h55, 8'h44}
) (
  // pins from the host
  input wire logic clk,
  input wire logic [12:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  input wire logic id_hv,
  // data back to the host
  output logic [7:0] dq_i
);
  logic [7:0] mem [16384];
  logic [7:0] pg [64];
  logic [63:0] pv = '0;
  logic [7:0] pbase, last_d = '0, last_o = '0, wd;
  logic [12:0] wa;
  logic [1:0] son = '0, soff = '0, nb = '0;
  logic lock = 1'b0, tog = 1'b0, rd_q = 1'b0, wa_q = 1'b0, ld = 1'b0, rd, wact, pol;
  int stb = 0, win = 0, busy = 0;
  initial for (int i = 0; i < 16384; i++) mem[i] = 8'hff;

  // ==========================================================
  // pin decode; a released bus shows the inverse of its last level
  assign rd = !ce_n && !oe_n && we_n;
  assign wact = !ce_n && !we_n && oe_n;
  assign pol = ld || busy > 0; // reads during load poll too
  assign wd = dq_oe ? dq_o : ~dq_o;
  assign dq_i = !rd ? ~last_o :
    pol ? {~last_d[7], tog, last_d[5:0]} : mem[{id_hv, addr}];

  // ==========================================================
  // byte capture, page buffer and internal programming timer
  always @(posedge clk) begin
    rd_q <= rd;
    wa_q <= wact;
    if (rd) last_o <= dq_i;
    if (rd && !rd_q && pol) tog <= ~tog;
    if (wact && !wa_q) begin // address at the later fall
      wa <= addr;
      stb <= 1;
    end else if (wact) stb <= stb + 1;
    if (!wact && wa_q && stb >= 2 && busy == 0) begin // data at first rise
      ld <= 1'b1;
      win <= WIN_CYC;
      last_d <= wd;
      if (nb < 2'h3) nb <= nb + 2'h1;
      if (nb < 2'h3 && son == nb && wa == ON_A[nb] && wd == ON_D[nb]) son <= son + 2'h1;
      else if (nb < 2'h3 && soff == nb && wa == OFF_A[nb] && wd == OFF_D[nb]) begin
        soff <= soff + 2'h1;
      end else begin // command bytes never reach the buffer
        pg[wa[5:0]] <= wd;
        pv[wa[5:0]] <= 1'b1;
        if (pv == '0) pbase <= {id_hv, wa[12:6]};
      end
    end else if (ld && win > 0) win <= win - 1;
    else if (ld) begin // window ran out, program the page
      ld <= 1'b0;
      busy <= PROG_CYC;
      {nb, son, soff, pv} <= '0;
      if (son == 2'h3) lock <= 1'b1;
      if (soff == 2'h3) lock <= 1'b0; // only the off sequence clears it
      for (int i = 0; i < 64; i++) begin
        if (pv[i] && (!lock || son == 2'h3)) mem[{pbase, 6'(i)}] <= pg[i];
      end
    end
    if (busy > 0) busy <= busy - 1;
  end
endmodule

// file: verif/pepw_host_bench.sv
// self-checking bench for the eeprom host controller
// assumes the behavioural eeprom model and the bound pin checker
`timescale 1ns/1ps
module pepw_host_bench;
  localparam int LOCK = 50;
  localparam int PROG = 300;
  logic CLK = 1'b0, RESET_N = 1'b0, CMD_VALID = 1'b0, CMD_LAST = 1'b0, CMD_ID = 1'b0;
  logic SUPPLY_GOOD = 1'b0;
  logic [2:0] CMD_OP = 3'h0;
  logic [12:0] CMD_ADDR = 13'h0000, EE_ADDR;
  logic [7:0] CMD_DATA = 8'h00, RSP_DATA, EE_DQ_I, EE_DQ_O, r;
  logic CMD_READY, RSP_VALID, WRITE_READY, EE_CE_N, EE_OE_N, EE_WE_N, EE_DQ_OE, EE_ID_HV;
  int num_errors = 0, num_checks = 0, lat;

  // ==========================================================
  // design and far-side model; short window and lockout keep the run brief
  pepw_host #(.BLW_CYC(200), .LOCKOUT_CYC(LOCK)) i_dut (.CLK(CLK), .RESET_N(RESET_N),
    .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
    .CMD_DATA(CMD_DATA), .CMD_LAST(CMD_LAST), .CMD_ID(CMD_ID), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .SUPPLY_GOOD(SUPPLY_GOOD), .WRITE_READY(WRITE_READY),
    .EE_ADDR(EE_ADDR), .EE_CE_N(EE_CE_N), .EE_OE_N(EE_OE_N), .EE_WE_N(EE_WE_N),
    .EE_DQ_I(EE_DQ_I), .EE_DQ_O(EE_DQ_O), .EE_DQ_OE(EE_DQ_OE), .EE_ID_HV(EE_ID_HV));
  pepw_eeprom_model #(.PROG_CYC(PROG)) i_ee (.clk(CLK), .addr(EE_ADDR), .ce_n(EE_CE_N),
    .oe_n(EE_OE_N), .we_n(EE_WE_N), .dq_o(EE_DQ_O), .dq_oe(EE_DQ_OE), .id_hv(EE_ID_HV),
    .dq_i(EE_DQ_I));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one command, held until taken, then wait for its answer
  task automatic cmd(input logic [2:0] op, input logic [12:0] a, input logic [7:0] d,
                     input logic last, input logic id);
    int n;
    n = 0;
    CMD_VALID <= 1'b1;
    CMD_OP <= op;
    CMD_ADDR <= a;
    CMD_DATA <= d;
    CMD_LAST <= last;
    CMD_ID <= id;
    do begin
      @(posedge CLK);
      n++;
    end while (CMD_READY !== 1'b1 && n < 20000);
    CMD_VALID <= 1'b0;
    lat = 0;
    do begin
      @(posedge CLK);
      lat++;
    end while (RSP_VALID !== 1'b1 && lat < 20000);
    r = RSP_DATA;
    if (n >= 20000 || lat >= 20000) check(8'h00, 8'h01);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic last);
    cmd(pepw_pkg::OP_WRITE, a, d, last, 1'b0);
  endtask
  task automatic rdc(input logic [12:0] a, input logic id, input logic [7:0] exp);
    cmd(pepw_pkg::OP_READ, a, 8'h00, 1'b0, id);
    check(r, exp);
  endtask
  task automatic power_up;
    SUPPLY_GOOD <= 1'b1;
    repeat (LOCK) @(posedge CLK);
    check({7'h0, WRITE_READY}, 8'h00);
    repeat (5) @(posedge CLK);
    check({7'h0, WRITE_READY}, 8'h01);
  endtask
  task automatic power_cycle;
    SUPPLY_GOOD <= 1'b0;
    repeat (4) @(posedge CLK);
    check({7'h0, WRITE_READY}, 8'h00);
    power_up();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_page; // out of order, one byte reloaded, page left partial
    wr(13'h0405, 8'h11, 1'b0);
    wr(13'h0401, 8'h22, 1'b0);
    wr(13'h0405, 8'h5a, 1'b0);
    wr(13'h0402, 8'h81, 1'b1);
    check(r, 8'h81);
    check({7'h0, lat > PROG}, 8'h01);
    rdc(13'h0405, 1'b0, 8'h5a);
    rdc(13'h0401, 1'b0, 8'h22);
    rdc(13'h0403, 1'b0, 8'hff);
  endtask
  task automatic t_window; // no last byte: the load closes by itself
    wr(13'h0810, 8'h3c, 1'b0);
    repeat (700) @(posedge CLK);
    rdc(13'h0810, 1'b0, 8'h3c);
    // a read or another page during an open load: the host finishes the load first
    wr(13'h0820, 8'h5a, 1'b0);
    rdc(13'h0820, 1'b0, 8'h5a);
    wr(13'h0860, 8'h0f, 1'b0);
    wr(13'h08a0, 8'hf0, 1'b1);
    rdc(13'h0860, 1'b0, 8'h0f);
    rdc(13'h08a0, 1'b0, 8'hf0);
  endtask
  task automatic t_lock;
    cmd(pepw_pkg::OP_LOCK_ON, 13'h0000, 8'h00, 1'b1, 1'b0);
    power_cycle();
    wr(13'h0c00, 8'hc3, 1'b1);
    check({7'h0, lat > PROG}, 8'h01);
    rdc(13'h0c00, 1'b0, 8'hff);
    cmd(pepw_pkg::OP_WRITE_PROT, 13'h0c01, 8'h44, 1'b1, 1'b0);
    rdc(13'h0c01, 1'b0, 8'h44);
    rdc(13'h0002, 1'b0, 8'hff);
    cmd(pepw_pkg::OP_LOCK_OFF, 13'h0000, 8'h00, 1'b1, 1'b0);
    wr(13'h0001, 8'h77, 1'b1);
    rdc(13'h0001, 1'b0, 8'h77);
  endtask
  task automatic t_id;
    cmd(pepw_pkg::OP_WRITE, 13'h0005, 8'h3c, 1'b1, 1'b1);
    rdc(13'h0005, 1'b1, 8'h3c);
    rdc(13'h1fc5, 1'b0, 8'hff);
  endtask

  // ==========================================================
  // clock, main sequence and watchdog
  initial forever #4 CLK = ~CLK;
  initial begin
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    power_up();
    power_cycle();
    t_page();
    t_window();
    t_lock();
    t_id();
    end_sim();
  end
  // generous bound over the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge CLK);
    num_errors++;
    end_sim();
  end
endmodule
